/* common/ppe_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PPE_CONSTS_SVH
`define PPE_CONSTS_SVH

`define PPE_ADDR_W 8
`define PPE_OFS_STAT 8'hEC
`define PPE_OFS_PORT_CONTROL_REG 8'hF0
`define PPE_OFS_PERIPHERAL_ADDRESS_OR_LOW_PINS 8'hF4
`define PPE_OFS_PERIPHERAL_DATA_OR_HIGH_PINS 8'hF8
`define PPE_OFS_EEPROM_PIN_DRIVE 8'hFC

`define PPE_PORT_CONTROL_REG_MODE_BIT 7
`define PPE_PORT_CONTROL_REG_RST 8'h00
`define PPE_EEPROM_PIN_DRIVE_EN_BIT 3
`define PPE_EEPROM_PIN_DRIVE_CLK_BIT 2
`define PPE_EEPROM_PIN_DRIVE_SEL_BIT 1
`define PPE_EEPROM_PIN_DRIVE_OUT_BIT 0
`define PPE_EEPROM_PIN_DRIVE_RST 8'h00

`define PPE_CLK_NS 20
`define PPE_ALE_NS 40
`define PPE_HOLD_NS 20
`define PPE_STB_NS 100
`define PPE_CEIL_CYC(ns) (((ns) + `PPE_CLK_NS - 1) / `PPE_CLK_NS)
`define PPE_ALE_CYC `PPE_CEIL_CYC(`PPE_ALE_NS)
`define PPE_HOLD_CYC `PPE_CEIL_CYC(`PPE_HOLD_NS)
`define PPE_STB_CYC `PPE_CEIL_CYC(`PPE_STB_NS)

`endif

/* common/ppe_pkg.sv */
// Types shared by the peripheral port block and its bus sequencer
package ppe_pkg;

  typedef struct packed {
    logic port_mode_select;
    logic rsvd;
    logic dir_pin_10;
    logic dir_pins_9_8;
    logic [3:0] dir_pins_lo;
  } ppe_port_control_reg_type;

  typedef struct packed {
    logic [7:0] ad_o;
    logic ad_oe;
    logic addr_latch_strobe;
    logic rd_n;
    logic wr_n;
  } ppe_xbus_type;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_XBUS = 3'b010,
    ACC_ACK = 3'b100
  } ppe_acc_state_type;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'b00001,
    SEQ_ALE = 5'b00010,
    SEQ_HOLD = 5'b00100,
    SEQ_STB = 5'b01000,
    SEQ_DONE = 5'b10000
  } ppe_seq_state_type;

endpackage

/* rtl/ppe_xbus_seq.sv */
// Multiplexed address/data bus access sequencer
`timescale 1ns/1ns
`include "ppe_consts.svh"

module ppe_xbus_seq import ppe_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic is_wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] bus_in,
  output ppe_xbus_type xbus,
  output logic [7:0] rdata,
  output logic done
);

  ppe_seq_state_type state_r;
  logic [3:0] cnt_r;
  logic wr_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= SEQ_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      xbus <= '{ad_o: 8'h00, ad_oe: 1'b0, addr_latch_strobe: 1'b0,
                rd_n: 1'b1, wr_n: 1'b1};
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        SEQ_IDLE: begin
          if (start) begin
            xbus.ad_o <= addr;
            xbus.ad_oe <= 1'b1;
            xbus.addr_latch_strobe <= 1'b1;
            wr_r <= is_wr;
            cnt_r <= 4'(`PPE_ALE_CYC - 1);
            state_r <= SEQ_ALE;
          end
        end
        SEQ_ALE: begin
          if (cnt_r == 4'h0) begin
            // Address stays on the bus past the falling latch edge
            xbus.addr_latch_strobe <= 1'b0;
            cnt_r <= 4'(`PPE_HOLD_CYC - 1);
            state_r <= SEQ_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        SEQ_HOLD: begin
          if (cnt_r == 4'h0) begin
            if (wr_r) begin
              xbus.ad_o <= wdata;
              xbus.wr_n <= 1'b0;
            end else begin
              xbus.ad_oe <= 1'b0;
              xbus.rd_n <= 1'b0;
            end
            cnt_r <= 4'(`PPE_STB_CYC - 1);
            state_r <= SEQ_STB;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        SEQ_STB: begin
          if (cnt_r == 4'h0) begin
            if (!wr_r) begin
              rdata <= bus_in;
            end
            xbus.rd_n <= 1'b1;
            xbus.wr_n <= 1'b1;
            xbus.ad_oe <= 1'b0;
            done <= 1'b1;
            state_r <= SEQ_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        SEQ_DONE: begin
          state_r <= SEQ_IDLE;
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

endmodule // ppe_xbus_seq

/* rtl/ppe_port.sv */
// Peripheral port, auxiliary pins and EEPROM bit-bang pins
`timescale 1ns/1ns
`include "ppe_consts.svh"

module ppe_port import ppe_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [7:0] AUX_LO_I,
  output logic [7:0] AUX_LO_O,
  output logic [7:0] AUX_LO_OE,
  input wire logic [2:0] AUX_HI_I,
  output logic [2:0] AUX_HI_O,
  output logic [2:0] AUX_HI_OE,
  output logic EEPROM_CLK_PIN_O,
  output logic EEPROM_CLK_PIN_OE,
  output logic EEPROM_SELECT_PIN_O,
  output logic EEPROM_SELECT_PIN_OE,
  output logic EEPROM_OUT_PIN_O,
  output logic EEPROM_OUT_PIN_OE
);

  // Picks pin level for inputs and stored bit for outputs, per bit
  function automatic logic [7:0] ppe_mix(input logic [7:0] stored,
                                         input logic [7:0] pins,
                                         input logic [7:0] oe);
    ppe_mix = (pins & ~oe) | (stored & oe);
  endfunction

  // Offset compare, shared by every decoder below
  function automatic logic ppe_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    ppe_hit = (a == ofs);
  endfunction

  ppe_port_control_reg_type port_control_reg_r;
  logic [7:0] peripheral_address_or_low_pins_r;
  logic [7:0] peripheral_data_or_high_pins_r;
  logic [3:0] eeprom_pin_drive_r;
  ppe_acc_state_type acc_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic last_rd_r;

  logic [7:0] lo_oe;
  logic [2:0] hi_oe;
  logic mux_mode;
  logic req;
  logic wr_lane;
  logic hit_peripheral_data_or_high_pins_mux;
  logic seq_start;
  logic seq_done;
  logic [7:0] seq_rdata;
  ppe_xbus_type xbus;
  logic [31:0] rd_value;
  logic [7:0] lo_o_nxt;
  logic [7:0] lo_oe_nxt;
  logic [2:0] hi_o_nxt;
  logic [2:0] hi_oe_nxt;

  assign mux_mode = port_control_reg_r.port_mode_select;
  assign req = AVS_READ | AVS_WRITE;
  assign wr_lane = AVS_WRITE & AVS_BYTEENABLE[0];

  // One direction bit per pin pair on the low group
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lo_dir
      assign lo_oe[2*g+1:2*g] =
        {2{port_control_reg_r.dir_pins_lo[g]}};
    end
  endgenerate

  assign hi_oe = {port_control_reg_r.dir_pin_10,
                  {2{port_control_reg_r.dir_pins_9_8}}};

  // In bus mode the data register is a window onto the peripheral
  assign hit_peripheral_data_or_high_pins_mux = mux_mode &
    ppe_hit(AVS_ADDRESS, `PPE_OFS_PERIPHERAL_DATA_OR_HIGH_PINS);
  assign seq_start = (acc_r == ACC_IDLE) & req & hit_peripheral_data_or_high_pins_mux;

  // The sequencer owns the strobe timing; this module only gates it
  ppe_xbus_seq ppe_xbus_seq_inst (
    .clk(CLK_SYS),
    .srst(SRST),
    .start(seq_start),
    .is_wr(AVS_WRITE),
    .addr(peripheral_address_or_low_pins_r),
    .wdata(AVS_WRITEDATA[7:0]),
    .bus_in(AUX_LO_I),
    .xbus(xbus),
    .rdata(seq_rdata),
    .done(seq_done)
  );

  // Read value for a plain register access
  always_comb begin
    rd_value = 32'h0000_0000;
    if (ppe_hit(AVS_ADDRESS, `PPE_OFS_PORT_CONTROL_REG)) begin
      rd_value[7:0] = port_control_reg_r;
    end else if (ppe_hit(AVS_ADDRESS, `PPE_OFS_PERIPHERAL_ADDRESS_OR_LOW_PINS)) begin
      if (mux_mode) begin
        rd_value[7:0] = peripheral_address_or_low_pins_r;
      end else begin
        rd_value[7:0] = ppe_mix(peripheral_address_or_low_pins_r,
                                AUX_LO_I, lo_oe);
      end
    end else if (ppe_hit(AVS_ADDRESS, `PPE_OFS_PERIPHERAL_DATA_OR_HIGH_PINS)) begin
      rd_value[7:0] = ppe_mix({5'h00, peripheral_data_or_high_pins_r[2:0]},
                              {5'h00, AUX_HI_I},
                              {5'h00, hi_oe});
    end else if (ppe_hit(AVS_ADDRESS, `PPE_OFS_STAT)) begin
      // Polling is optional: the bus stalls until a muxed access is done
      rd_value[0] = (acc_r == ACC_XBUS);
      rd_value[1] = last_rd_r;
      rd_value[2] = mux_mode;
    end
  end

  // Access sequencing and waitrequest; wait idles high so every answer
  // is a registered low pulse of exactly one cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      acc_r <= ACC_IDLE;
      wait_r <= 1'b1;
    end else begin
      case (acc_r)
        ACC_IDLE: begin
          if (seq_start) begin
            acc_r <= ACC_XBUS;
          end else if (req) begin
            wait_r <= 1'b0;
            acc_r <= ACC_ACK;
          end
        end
        ACC_XBUS: begin
          if (seq_done) begin
            wait_r <= 1'b0;
            acc_r <= ACC_ACK;
          end
        end
        ACC_ACK: begin
          wait_r <= 1'b1;
          acc_r <= ACC_IDLE;
        end
        default: begin
          wait_r <= 1'b1;
          acc_r <= ACC_IDLE;
        end
      endcase
    end
  end

  assign AVS_WAITREQUEST = wait_r;

  // Read data is loaded together with the falling waitrequest
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rdata_r <= 32'h0000_0000;
    end else if (acc_r == ACC_IDLE && req && !seq_start) begin
      rdata_r <= AVS_READ ? rd_value : 32'h0000_0000;
    end else if (acc_r == ACC_XBUS && seq_done) begin
      rdata_r <= AVS_READ ? {24'h000000, seq_rdata} : 32'h0000_0000;
    end
  end

  assign AVS_READDATA = rdata_r;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      last_rd_r <= 1'b0;
    end else if (acc_r == ACC_ACK) begin
      last_rd_r <= AVS_READ;
    end
  end

  // Writes land on the edge that retires the access
  // Bit 6 is stored but drives nothing
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      port_control_reg_r <= `PPE_PORT_CONTROL_REG_RST;
    end else if (acc_r == ACC_ACK && wr_lane &&
                 ppe_hit(AVS_ADDRESS, `PPE_OFS_PORT_CONTROL_REG)) begin
      port_control_reg_r <= AVS_WRITEDATA[7:0];
    end
  end

  // No reset here on purpose: contents are undefined until written
  always_ff @(posedge CLK_SYS) begin
    if (acc_r == ACC_ACK && wr_lane &&
        ppe_hit(AVS_ADDRESS, `PPE_OFS_PERIPHERAL_ADDRESS_OR_LOW_PINS)) begin
      peripheral_address_or_low_pins_r <= AVS_WRITEDATA[7:0];
    end
  end

  // A bus-mode read also leaves the fetched byte in the data register
  always_ff @(posedge CLK_SYS) begin
    if (acc_r == ACC_ACK && ppe_hit(AVS_ADDRESS, `PPE_OFS_PERIPHERAL_DATA_OR_HIGH_PINS)) begin
      if (hit_peripheral_data_or_high_pins_mux && AVS_READ) begin
        peripheral_data_or_high_pins_r <= seq_rdata;
      end else if (wr_lane) begin
        peripheral_data_or_high_pins_r <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // Write-only: a read of this offset falls through to zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      eeprom_pin_drive_r <= 4'(`PPE_EEPROM_PIN_DRIVE_RST);
    end else if (acc_r == ACC_ACK && wr_lane &&
                 ppe_hit(AVS_ADDRESS, `PPE_OFS_EEPROM_PIN_DRIVE)) begin
      eeprom_pin_drive_r <= AVS_WRITEDATA[3:0];
    end
  end

  // Pin drive; masking with the enable keeps undefined register
  // contents off released pins
  always_comb begin
    if (mux_mode) begin
      lo_o_nxt = xbus.ad_o;
      lo_oe_nxt = {8{xbus.ad_oe}};
      hi_o_nxt = {xbus.wr_n, xbus.rd_n, xbus.addr_latch_strobe};
      hi_oe_nxt = 3'h7;
    end else begin
      lo_o_nxt = peripheral_address_or_low_pins_r & lo_oe;
      lo_oe_nxt = lo_oe;
      hi_o_nxt = peripheral_data_or_high_pins_r[2:0] & hi_oe;
      hi_oe_nxt = hi_oe;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      AUX_LO_O <= 8'h00;
      AUX_LO_OE <= 8'h00;
      AUX_HI_O <= 3'h0;
      AUX_HI_OE <= 3'h0;
    end else begin
      AUX_LO_O <= lo_o_nxt;
      AUX_LO_OE <= lo_oe_nxt;
      AUX_HI_O <= hi_o_nxt;
      AUX_HI_OE <= hi_oe_nxt;
    end
  end

  // EEPROM pins follow the drive register straight from its flops
  assign EEPROM_CLK_PIN_O =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_CLK_BIT];
  assign EEPROM_SELECT_PIN_O =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_SEL_BIT];
  assign EEPROM_OUT_PIN_O =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_OUT_BIT];
  assign EEPROM_CLK_PIN_OE =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_EN_BIT];
  assign EEPROM_SELECT_PIN_OE =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_EN_BIT];
  assign EEPROM_OUT_PIN_OE =
    eeprom_pin_drive_r[`PPE_EEPROM_PIN_DRIVE_EN_BIT];

endmodule // ppe_port

/* dv/ppe_port_asserts.sv */
// Pin and register bus checks for the peripheral port
`timescale 1ns/1ns
module ppe_port_asserts (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [7:0] AUX_LO_O,
  input wire logic [7:0] AUX_LO_OE,
  input wire logic [2:0] AUX_HI_O,
  input wire logic [2:0] AUX_HI_OE,
  input wire logic EEPROM_CLK_PIN_O,
  input wire logic EEPROM_CLK_PIN_OE,
  input wire logic EEPROM_SELECT_PIN_O,
  input wire logic EEPROM_SELECT_PIN_OE,
  input wire logic EEPROM_OUT_PIN_O,
  input wire logic EEPROM_OUT_PIN_OE
);
  logic mode_r, mode_q, wr_done;
  logic [5:0] dir_r, dir_q;
  logic [7:0] addr_r, lo_exp;
  assign wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  // Pins lag the registers by one flop, so compare against delayed copies
  assign lo_exp = {{2{dir_q[3]}}, {2{dir_q[2]}}, {2{dir_q[1]}}, {2{dir_q[0]}}};
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      mode_r <= 1'b0;
      dir_r <= 6'h00;
    end else if (wr_done && AVS_ADDRESS == 8'hF0) begin
      mode_r <= AVS_WRITEDATA[7];
      dir_r <= AVS_WRITEDATA[5:0];
    end
  end
  always_ff @(posedge CLK_SYS) begin
    mode_q <= SRST ? 1'b0 : mode_r;
    dir_q <= SRST ? 6'h00 : dir_r;
  end
  always_ff @(posedge CLK_SYS) begin
    if (wr_done && AVS_ADDRESS == 8'hF4) begin
      addr_r <= AVS_WRITEDATA[7:0];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  wait_pulse_a: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  bus_strobes_a: assert property (
    mode_r && mode_q |-> AUX_HI_OE == 3'h7)
    else $error("strobe pins not driven in bus mode");
  low_dir_a: assert property (
    !mode_r && !mode_q |-> AUX_LO_OE == lo_exp)
    else $error("low pin enables wrong");
  high_dir_a: assert property (
    !mode_r && !mode_q |-> AUX_HI_OE == {dir_q[5], dir_q[4], dir_q[4]})
    else $error("high pin enables wrong");
  low_out_a: assert property (
    wr_done && AVS_ADDRESS == 8'hF4 && !mode_r |->
    ##2 ((AUX_LO_O ^ $past(AVS_WRITEDATA[7:0], 2)) & AUX_LO_OE) == 8'h00)
    else $error("driven low pins wrong");
  eeprom_en_a: assert property (wr_done && AVS_ADDRESS == 8'hFC |=>
    {EEPROM_CLK_PIN_OE, EEPROM_SELECT_PIN_OE, EEPROM_OUT_PIN_OE} ==
    {3{$past(AVS_WRITEDATA[3])}}) else $error("eeprom enables wrong");
  eeprom_bits_a: assert property (wr_done && AVS_ADDRESS == 8'hFC &&
    AVS_WRITEDATA[3] |=> {EEPROM_CLK_PIN_O, EEPROM_SELECT_PIN_O,
    EEPROM_OUT_PIN_O} == $past(AVS_WRITEDATA[2:0])) else $error("eeprom bits");
  latch_width_a: assert property (mode_q && $rose(AUX_HI_O[0]) |->
    AUX_HI_O[0] [*2] ##1 !AUX_HI_O[0]) else $error("latch strobe width");
  addr_phase_a: assert property (mode_q && AUX_HI_O[0] |->
    AUX_LO_OE == 8'hFF && AUX_LO_O == addr_r) else $error("address phase");
  write_drive_a: assert property (
    mode_q && !AUX_HI_O[2] |-> AUX_LO_OE == 8'hFF)
    else $error("write data not driven");
  read_release_a: assert property (
    mode_q && !AUX_HI_O[1] |-> AUX_LO_OE == 8'h00)
    else $error("bus not released on read");
  strobe_width_a: assert property (mode_q && $fell(AUX_HI_O[2]) |->
    !AUX_HI_O[2] [*5] ##1 AUX_HI_O[2]) else $error("write strobe width");
  cover property (mode_q && $rose(AUX_HI_O[0]));
  cover property (mode_q && $fell(AUX_HI_O[1]));
  cover property (wr_done && AVS_ADDRESS == 8'hFC && AVS_WRITEDATA[3]);
endmodule // ppe_port_asserts

bind ppe_port ppe_port_asserts ppe_port_asserts_inst (.CLK_SYS(CLK_SYS),
  .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .AUX_LO_O(AUX_LO_O),
  .AUX_LO_OE(AUX_LO_OE), .AUX_HI_O(AUX_HI_O), .AUX_HI_OE(AUX_HI_OE),
  .EEPROM_CLK_PIN_O(EEPROM_CLK_PIN_O), .EEPROM_CLK_PIN_OE(EEPROM_CLK_PIN_OE),
  .EEPROM_SELECT_PIN_O(EEPROM_SELECT_PIN_O),
  .EEPROM_SELECT_PIN_OE(EEPROM_SELECT_PIN_OE),
  .EEPROM_OUT_PIN_O(EEPROM_OUT_PIN_O), .EEPROM_OUT_PIN_OE(EEPROM_OUT_PIN_OE));

/* dv/ppe_periph_model.sv */
// Behavioural peripheral on the multiplexed bus, IO-mode levels otherwise
`timescale 1ns/1ns
module ppe_periph_model (
  input wire logic clk,
  input wire logic active,
  input wire logic [7:0] io_lvl,
  input wire logic [7:0] lo_o,
  input wire logic [2:0] hi_o,
  output logic [7:0] lo_i
);
  logic [7:0] mem [0:255];
  logic [7:0] addr_q, last_q;
  always @(posedge clk) begin
    if (active && hi_o[0]) begin
      addr_q <= lo_o;
    end
    if (active && !hi_o[2]) begin
      mem[addr_q] <= lo_o;
    end
    if (active && !hi_o[1]) begin
      last_q <= mem[addr_q];
    end
  end
  // A released bus shows the inverted last byte so a late capture fails
  assign lo_i = !active ? io_lvl : !hi_o[1] ? mem[addr_q] : ~last_q;
endmodule // ppe_periph_model

/* dv/ppe_port_tb.sv */
// Self-checking bench for the peripheral port registers and pins
`timescale 1ns/1ns
module ppe_port_tb;
  logic clk, srst, rd, wr, mode_b;
  logic [7:0] addr, rv, m, io_lvl;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [2:0] hi_lvl, hm;
  wire [31:0] rdata;
  wire wreq, ck, cke, sl, sle, so, soe;
  wire [7:0] lo_i, lo_o, lo_oe;
  wire [2:0] hi_o, hi_oe;
  int bad_count, n_compared, edges;
  logic [7:0] dirs [2] = '{8'h25, 8'h1A};
  logic [7:0] adrs [2] = '{8'h00, 8'hFF};
  logic [7:0] dats [2] = '{8'h5A, 8'hC3};
  ppe_port ppe_port_inst (.CLK_SYS(clk), .SRST(srst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .AUX_LO_I(lo_i), .AUX_LO_O(lo_o), .AUX_LO_OE(lo_oe), .AUX_HI_I(hi_lvl),
    .AUX_HI_O(hi_o), .AUX_HI_OE(hi_oe), .EEPROM_CLK_PIN_O(ck),
    .EEPROM_CLK_PIN_OE(cke), .EEPROM_SELECT_PIN_O(sl),
    .EEPROM_SELECT_PIN_OE(sle), .EEPROM_OUT_PIN_O(so),
    .EEPROM_OUT_PIN_OE(soe));
  ppe_periph_model ppe_periph_model_inst (.clk(clk), .active(mode_b),
    .io_lvl(io_lvl), .lo_o(lo_o), .hi_o(hi_o), .lo_i(lo_i));
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v,
                     input logic [3:0] b);
    addr <= a;
    wdata <= {24'h000000, v};
    be <= b;
    wr <= w;
    rd <= !w;
    edges = 0;
    do begin
      @(posedge clk);
      edges++;
    end while (wreq !== 1'b0 && edges < 100);
    if (edges >= 100) begin
      bad_count++;
      complete_run();
    end
    rv = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {srst, rd, wr, addr, wdata, be, mode_b} = {1'b1, 47'h0};
    io_lvl = 8'h3C;
    hi_lvl = 3'h2;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    acc(0, 8'hF0, 8'h00, 4'hF);
    cmp8(rv, 8'h00);
    cmp8(8'(edges), 8'h02);
    acc(0, 8'hFC, 8'h00, 4'hF);
    cmp8(rv, 8'h00);
    acc(0, 8'h10, 8'h00, 4'hF);
    cmp8(rv, 8'h00);
    cmp8({5'h00, cke, sle, soe}, 8'h00);
    foreach (dirs[i]) begin
      acc(1, 8'hF0, dirs[i], 4'hF);
      m = {{2{dirs[i][3]}}, {2{dirs[i][2]}},
           {2{dirs[i][1]}}, {2{dirs[i][0]}}};
      hm = {dirs[i][5], dirs[i][4], dirs[i][4]};
      acc(1, 8'hF4, 8'hA5, 4'hF);
      acc(0, 8'hF4, 8'h00, 4'hF);
      cmp8(rv, (8'hA5 & m) | (io_lvl & ~m));
      cmp8(lo_oe, m);
      cmp8(lo_o & m, 8'hA5 & m);
      acc(1, 8'hF8, 8'h07, 4'hF);
      acc(0, 8'hF8, 8'h00, 4'hF);
      cmp8(rv, {5'h00, hm | (hi_lvl & ~hm)});
      cmp8({5'h00, hi_oe}, {5'h00, hm});
      cmp8({5'h00, hi_o & hm}, {5'h00, hm});
    end
    acc(1, 8'hF4, 8'h00, 4'hE);
    acc(0, 8'hF4, 8'h00, 4'hF);
    cmp8(rv, (8'hA5 & m) | (io_lvl & ~m));
    for (int v = 0; v < 16; v++) begin
      acc(1, 8'hFC, 8'(v), 4'hF);
      cmp8({5'h00, cke, sle, soe}, {5'h00, {3{v[3]}}});
      if (v[3]) cmp8({5'h00, ck, sl, so}, {5'h00, 3'(v)});
    end
    acc(1, 8'hF0, 8'h80, 4'hF);
    mode_b <= 1'b1;
    foreach (adrs[i]) begin
      acc(1, 8'hF4, adrs[i], 4'hF);
      acc(1, 8'hF8, dats[i], 4'hF);
      cmp8(8'(edges), 8'h0B);
      cmp8(ppe_periph_model_inst.mem[adrs[i]], dats[i]);
      acc(0, 8'hF4, 8'h00, 4'hF);
      cmp8(rv, adrs[i]);
    end
    foreach (adrs[i]) begin
      acc(1, 8'hF4, adrs[i], 4'hF);
      acc(0, 8'hF8, 8'h00, 4'hF);
      cmp8(rv, dats[i]);
    end
    // Status: idle, last access a read, bus mode
    acc(0, 8'hEC, 8'h00, 4'hF);
    cmp8(rv, 8'h06);
    complete_run();
  end
endmodule // ppe_port_tb
